// ---- core/simd_fp_exception_classifier.v ----
/*
 SIMD floating-point exception classifier with a Wishbone
 classic register slave, sticky status, interrupt and counters.
 Registers by byte offset: control 0x00, sticky status 0x04
 (write one to clear), interrupt mask 0x08, last result 0x0C,
 classified count 0x10, reported count 0x14, per-condition
 hit counts 0x18 and 0x1C.
 Assumes decoder and datapath inputs are synchronous to clk_i
 and that the datapath presents its detected conditions in the
 same cycle as the decoded class.
*/
// Implementation choices: the Wishbone register port and the placing of the registers.
// How it works
// - Alternating add/sub packed double: I, D, O, U, P eligible; never Z.
// - Alternating add/sub packed single: I, D, O, U, P eligible; never Z.
// - Horizontal add packed double: I, D, O, U, P eligible; never Z.
// - Horizontal add packed single: I, D, O, U, P eligible; never Z.
// - Horizontal subtract packed double: I, D, O, U, P eligible; never Z.
// - Horizontal subtract packed single: I, D, O, U, P eligible; never Z.
// - Other third-extension instructions raise no condition at all.
// - Supplemental integer-only instructions never raise any condition.
// - Round packed double: invalid, precision when imm allows, nothing else.
// - Round packed single: invalid, precision when imm allows, nothing else.
// - Round scalar double: invalid, precision when imm allows, nothing else.
// - Round scalar single: invalid, precision when imm allows, nothing else.
// - Immediate bit 3 clear enables precision; set suppresses it.
// - Other fourth-extension instructions raise no condition.
`timescale 1ns/100ps
`include "simd_fp_exc_consts.vh"

module simd_fp_exception_classifier #(
   parameter CNT_W = 16,
   parameter HIT_W = 8
) (
   // Clock and reset
   input  wire                clk_i,
   input  wire                rst_i,
   // Wishbone classic slave
   input  wire [7:0]          adr_i,
   input  wire [31:0]         dat_i,
   output reg  [31:0]         dat_o,
   input  wire                we_i,
   input  wire [3:0]          sel_i,
   input  wire                cyc_i,
   input  wire                stb_i,
   output reg                 ack_o,
   // Decoder and datapath side
   input  wire                in_valid_i,
   input  wire [`CLS_W-1:0]   class_i,
   input  wire [7:0]          imm_i,
   input  wire [`COND_W-1:0]  detect_i,
   // Status logic side
   output reg                 res_valid_o,
   output reg  [`COND_W-1:0]  elig_o,
   output reg  [`COND_W-1:0]  flags_o,
   // Interrupt
   output wire                irq_o
);

   // Maps a decoded class and its immediate to the eligible set.
   function [`COND_W-1:0] classify;
      input [`CLS_W-1:0] cls;
      input [7:0]        imm;
      begin
         case (cls)
            `CLS_ALT_ADDSUB_PD: begin
               classify = `MASK_ARITH;
            end
            `CLS_ALT_ADDSUB_PS: begin
               classify = `MASK_ARITH;
            end
            `CLS_HORIZ_ADD_PD: begin
               classify = `MASK_ARITH;
            end
            `CLS_HORIZ_ADD_PS: begin
               classify = `MASK_ARITH;
            end
            `CLS_HORIZ_SUB_PD: begin
               classify = `MASK_ARITH;
            end
            `CLS_HORIZ_SUB_PS: begin
               classify = `MASK_ARITH;
            end
            `CLS_ROUND_PD: begin
               classify = round_elig(imm);
            end
            `CLS_ROUND_PS: begin
               classify = round_elig(imm);
            end
            `CLS_ROUND_SD: begin
               classify = round_elig(imm);
            end
            `CLS_ROUND_SS: begin
               classify = round_elig(imm);
            end
            `CLS_OTHER_V3: begin
               classify = `MASK_NONE;
            end
            `CLS_SUPP_INT: begin
               classify = `MASK_NONE;
            end
            `CLS_OTHER_V4: begin
               classify = `MASK_NONE;
            end
            // Undefined codes are held silent rather than trusted.
            default: begin
               classify = `MASK_NONE;
            end
         endcase
      end
   endfunction

   // Rounding may flag invalid, and precision unless the immediate
   // asks for it to be suppressed.
   function [`COND_W-1:0] round_elig;
      input [7:0] imm;
      begin
         if (imm[`IMM_SUPPRESS_P]) begin
            round_elig = `MASK_INVALID;
         end else begin
            round_elig = `MASK_INVALID | `MASK_PRECISION;
         end
      end
   endfunction

   // True for a byte-0 write at the given register offset.
   function wr_at;
      input       wr;
      input [7:0] adr;
      input [7:0] off;
      begin
         wr_at = wr && (adr == off);
      end
   endfunction

   // Bus decode.
   wire       bus_req;
   wire       wr_lo;
   wire       rd_req;
   wire       wr_ctrl;
   wire       wr_status;
   wire       wr_mask;

   // Gating with ack_o keeps a held request from being taken twice.
   assign bus_req   = cyc_i & stb_i & ~ack_o;
   assign wr_lo     = bus_req & we_i & sel_i[0];
   assign rd_req    = bus_req & ~we_i;
   assign wr_ctrl   = wr_at(wr_lo, adr_i, `REG_CTRL);
   assign wr_status = wr_at(wr_lo, adr_i, `REG_STATUS);
   assign wr_mask   = wr_at(wr_lo, adr_i, `REG_IRQ_MASK);

   // Software state.
   reg                 enable_q;
   reg  [`COND_W-1:0]  irq_mask_q;
   reg  [`COND_W-1:0]  status_q;
   reg  [`COND_W-1:0]  status_d;
   reg  [`CLS_W-1:0]   last_cls_q;
   reg  [`COND_W-1:0]  last_flags_q;
   reg  [CNT_W-1:0]    classified_q;
   reg  [CNT_W-1:0]    reported_q;
   wire                cnt_clr;
   wire [`COND_W-1:0]  clr_bits;
   wire [`COND_W-1:0]  elig_d;
   wire [`COND_W-1:0]  flags_d;
   wire [HIT_W*`COND_W-1:0] hits;

   assign cnt_clr  = wr_ctrl && dat_i[`CTRL_CNT_CLR];
   assign clr_bits = wr_status ? dat_i[`COND_W-1:0] : `MASK_NONE;

   assign elig_d  = classify(class_i, imm_i);
   // Disabled reporting still tracks elig_o and the classified count.
   // gate detected conditions
   assign flags_d = enable_q ? (elig_d & detect_i) : `MASK_NONE;

   // Result stage: one cycle after the decoded instruction.
   always @(posedge clk_i) begin
      if (rst_i) begin
         res_valid_o <= 1'b0;
         elig_o      <= `MASK_NONE;
         flags_o     <= `MASK_NONE;
         last_cls_q  <= `CLS_OTHER_V3;
         last_flags_q <= `MASK_NONE;
      end else begin
         res_valid_o <= in_valid_i;
         if (in_valid_i) begin
            elig_o     <= elig_d;
            flags_o    <= flags_d;
            last_cls_q <= class_i;
            // The readable copy survives the idle cycles that clear flags_o.
            last_flags_q <= flags_d;
         end else begin
            flags_o    <= `MASK_NONE;
         end
      end
   end

   // Sticky status: a new event wins over a clear in the same cycle.
   always @* begin
      status_d = status_q & ~clr_bits;
      if (res_valid_o) begin
         status_d = status_d | flags_o;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         status_q <= `MASK_NONE;
      end else begin
         status_q <= status_d;
      end
   end

   assign irq_o = |(status_q & irq_mask_q);

   // Control and mask registers.
   always @(posedge clk_i) begin
      if (rst_i) begin
         enable_q   <= `CTRL_RESET;
         irq_mask_q <= `IRQ_MASK_RESET;
      end else begin
         if (wr_ctrl) begin
            enable_q <= dat_i[`CTRL_ENABLE];
         end
         if (wr_mask) begin
            irq_mask_q <= dat_i[`COND_W-1:0];
         end
      end
   end

   // Instruction counters; they wrap, software reads differences.
   always @(posedge clk_i) begin
      if (rst_i || cnt_clr) begin
         classified_q <= {CNT_W{1'b0}};
         reported_q   <= {CNT_W{1'b0}};
      end else if (res_valid_o) begin
         classified_q <= classified_q + {{(CNT_W-1){1'b0}}, 1'b1};
         if (|flags_o) begin
            reported_q <= reported_q + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // Per-condition hit counters, saturating so a busy condition
   // cannot wrap back to look quiet.
   genvar g;
   generate
      for (g = 0; g < `COND_W; g = g + 1) begin : hit_cnt
         reg [HIT_W-1:0] cnt_q;
         always @(posedge clk_i) begin
            if (rst_i || cnt_clr) begin
               cnt_q <= {HIT_W{1'b0}};
            end else if (res_valid_o && flags_o[g] && !(&cnt_q)) begin
               cnt_q <= cnt_q + {{(HIT_W-1){1'b0}}, 1'b1};
            end
         end
         assign hits[g*HIT_W +: HIT_W] = cnt_q;
      end
   endgenerate

   // Read mux; unmapped offsets answer with zero.
   reg [31:0] rd_d;
   always @* begin
      rd_d = 32'h00000000;
      case (adr_i)
         `REG_CTRL:       rd_d[`CTRL_ENABLE] = enable_q;
         `REG_STATUS:     rd_d[`COND_W-1:0] = status_q;
         `REG_IRQ_MASK:   rd_d[`COND_W-1:0] = irq_mask_q;
         `REG_LAST: begin
            rd_d[5:0]   = elig_o;
            rd_d[13:8]  = last_flags_q;
            rd_d[19:16] = last_cls_q;
         end
         `REG_CLASSIFIED: rd_d[CNT_W-1:0] = classified_q;
         `REG_REPORTED:   rd_d[CNT_W-1:0] = reported_q;
         `REG_HITS_LO:    rd_d[4*HIT_W-1:0] = hits[4*HIT_W-1:0];
         `REG_HITS_HI:    rd_d[2*HIT_W-1:0] = hits[6*HIT_W-1:4*HIT_W];
         default:         rd_d = 32'h00000000;
      endcase
   end

   // Every access is answered one cycle after it is seen.
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= bus_req;
         if (rd_req) begin
            dat_o <= rd_d;
         end
      end
   end

endmodule

// ---- common/simd_fp_exc_consts.vh ----
/*
 Constants for the SIMD floating-point exception classifier:
 condition bit positions, instruction class codes, register
 offsets and reset values. Assumes inclusion by bare name.
*/
`ifndef SIMD_FP_EXC_CONSTS_VH
`define SIMD_FP_EXC_CONSTS_VH

// Condition bit positions in every six-bit mask.
`define COND_W          6
`define COND_INVALID    0
`define COND_DENORMAL   1
`define COND_DIVZERO    2
`define COND_OVERFLOW   3
`define COND_UNDERFLOW  4
`define COND_PRECISION  5

// Eligibility patterns.
`define MASK_NONE       6'h00
`define MASK_ARITH      6'h3B
`define MASK_INVALID    6'h01
`define MASK_PRECISION  6'h20

// Immediate bit that suppresses precision on rounding.
`define IMM_SUPPRESS_P  3

// Instruction class codes from the decoder.
`define CLS_W                4
`define CLS_OTHER_V3         4'h0
`define CLS_ALT_ADDSUB_PD    4'h1
`define CLS_ALT_ADDSUB_PS    4'h2
`define CLS_HORIZ_ADD_PD     4'h3
`define CLS_HORIZ_ADD_PS     4'h4
`define CLS_HORIZ_SUB_PD     4'h5
`define CLS_HORIZ_SUB_PS     4'h6
`define CLS_ROUND_PD         4'h7
`define CLS_ROUND_PS         4'h8
`define CLS_ROUND_SD         4'h9
`define CLS_ROUND_SS         4'hA
`define CLS_SUPP_INT         4'hB
`define CLS_OTHER_V4         4'hC

// Register byte offsets.
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_IRQ_MASK    8'h08
`define REG_LAST        8'h0C
`define REG_CLASSIFIED  8'h10
`define REG_REPORTED    8'h14
`define REG_HITS_LO     8'h18
`define REG_HITS_HI     8'h1C

// Control fields and reset values.
`define CTRL_ENABLE     0
`define CTRL_CNT_CLR    1
`define CTRL_RESET      1'h1
`define IRQ_MASK_RESET  6'h00

`endif

// ---- verification/simd_fp_exc_props.sv ----
/*
 Checker for the exception classifier ports.
 Assumes binding to the classifier top module.
*/
`timescale 1ns/100ps
module simd_fp_exc_props (
   // Clock, reset and bus answer
   input wire       clk_i,
   input wire       rst_i,
   input wire       cyc_i,
   input wire       stb_i,
   input wire       ack_o,
   // Classifier path
   input wire       in_valid_i,
   input wire [3:0] class_i,
   input wire [7:0] imm_i,
   input wire [5:0] detect_i,
   input wire       res_valid_o,
   input wire [5:0] elig_o,
   input wire [5:0] flags_o,
   input wire       irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire arith = in_valid_i && class_i >= 4'h1 && class_i <= 4'h6;
   wire rnd   = in_valid_i && class_i >= 4'h7 && class_i <= 4'hA;
   wire quiet = in_valid_i && (class_i == 4'h0 || class_i == 4'hB || class_i == 4'hC);
   wire sup_p = imm_i[3];
   a_arith_mask: assert property (arith |=> elig_o == 6'h3B)
      else $error("arith mask wrong");
   a_round_mask: assert property (rnd |=> elig_o == ($past(sup_p) ? 6'h01 : 6'h21))
      else $error("round mask wrong");
   a_quiet_mask: assert property (quiet |=> elig_o == 6'h00)
      else $error("quiet mask wrong");
   a_valid_delay: assert property (in_valid_i |=> res_valid_o)
      else $error("result missing");
   a_valid_single: assert property (!in_valid_i |=> !res_valid_o)
      else $error("stray result");
   a_flags_subset: assert property (res_valid_o |-> (flags_o & ~elig_o) == 6'h00)
      else $error("flag outside mask");
   a_flags_and: assert property (res_valid_o && flags_o != 6'h00 |->
      flags_o == (elig_o & $past(detect_i)))
      else $error("flags not masked detect");
   a_flags_idle: assert property (!res_valid_o |-> flags_o == 6'h00)
      else $error("flags without result");
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus not answered");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack too long");
   cover property (arith ##1 flags_o != 6'h00);
   cover property (rnd && sup_p);
   cover property ($rose(irq_o));
endmodule

// ---- verification/simd_fp_issue_model.sv ----
/*
 Decoder and datapath stand-in that issues one instruction.
 Assumes the classifier samples on the rising clock edge.
*/
`timescale 1ns/100ps
module simd_fp_issue_model (
   // Clock
   input  wire       clk_i,
   // Decoded instruction
   output reg        valid_o,
   output reg  [3:0] class_o,
   output reg  [7:0] imm_o,
   output reg  [5:0] detect_o
);
   initial {valid_o, class_o, imm_o, detect_o} = 19'h0;
   task issue(input [3:0] c, input [7:0] i, input [5:0] d);
      begin
         @(posedge clk_i);
         valid_o  <= 1'b1;
         class_o  <= c;
         imm_o    <= i;
         detect_o <= d;
         @(posedge clk_i);
         valid_o  <= 1'b0;
         // Idle qualifiers flip so a stale value can never pass as live.
         class_o  <= ~c;
         imm_o    <= ~i;
         detect_o <= ~d;
      end
   endtask
endmodule

// ---- verification/tb_simd_fp_exception_classifier.sv ----
/*
 Testbench: bus reads and writes plus issued instructions.
 Assumes the register map and latencies of the classifier.
*/
`timescale 1ns/100ps
`include "simd_fp_exc_consts.vh"
module tb_simd_fp_exception_classifier;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg  [7:0]  adr = 8'h00;
   reg  [31:0] wdat = 32'h0;
   reg         we = 1'b0;
   reg         cyc = 1'b0;
   reg  [3:0]  sel = 4'h0;
   reg  [3:0]  wsel = 4'hF;
   reg  [31:0] rd_q;
   wire [31:0] rdat;
   wire        ack, vld, res_vld, irq;
   wire [3:0]  cls;
   wire [7:0]  imm;
   wire [5:0]  det, elig, flags;
   integer     bad_count = 0;
   integer     n_compared = 0;
   integer     k;
   always #12.5 clk = ~clk;
   simd_fp_issue_model i_model (.clk_i(clk), .valid_o(vld), .class_o(cls), .imm_o(imm),
      .detect_o(det));
   simd_fp_exception_classifier i_dut (.clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(wdat),
      .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(cyc), .ack_o(ack),
      .in_valid_i(vld), .class_i(cls), .imm_i(imm), .detect_i(det), .res_valid_o(res_vld),
      .elig_o(elig), .flags_o(flags), .irq_o(irq));
   task chk(input [12*8-1:0] what, input [31:0] exp, input [31:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task bus(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         cyc  <= 1'b1;
         we   <= w;
         adr  <= a;
         wdat <= d;
         sel  <= wsel;
         @(posedge clk);
         while (ack !== 1'b1) @(posedge clk);
         rd_q = rdat;
         cyc  <= 1'b0;
         we   <= 1'b0;
         sel  <= 4'h0;
         #1;
      end
   endtask
   function [5:0] mask(input [3:0] c, input s);
      mask = (c >= 4'h1 && c <= 4'h6) ? 6'h3B :
             (c >= 4'h7 && c <= 4'hA) ? (s ? 6'h01 : 6'h21) : 6'h00;
   endfunction
   task summarize;
      begin
         $display("compared %0d mismatched %0d", n_compared, bad_count);
         if (bad_count == 0 && n_compared > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(0, `REG_CTRL, 0);
      chk("ctrl", 32'h1, rd_q);
      bus(0, `REG_IRQ_MASK, 0);
      chk("mask", 32'h0, rd_q);
      bus(0, 8'h40, 0);
      chk("unmapped", 32'h0, rd_q);
      $display("test registers done");
      for (k = 0; k < 32; k = k + 1) begin
         i_model.issue(k[4:1], {4'hA, k[0], 3'h5}, 6'h3F);
         #1;
         chk("valid", 32'h1, {31'h0, res_vld});
         chk("elig", {26'h0, mask(k[4:1], k[0])}, {26'h0, elig});
         chk("flags", {26'h0, mask(k[4:1], k[0])}, {26'h0, flags});
      end
      i_model.issue(4'h2, 8'h00, 6'h24);
      #1;
      chk("partial", 32'h20, {26'h0, flags});
      $display("test classes done");
      bus(0, `REG_STATUS, 0);
      chk("status", 32'h3B, rd_q);
      chk("irq", 32'h0, {31'h0, irq});
      bus(1, `REG_IRQ_MASK, 32'h08);
      chk("irq on", 32'h1, {31'h0, irq});
      bus(1, `REG_STATUS, 32'h08);
      chk("irq off", 32'h0, {31'h0, irq});
      bus(0, `REG_STATUS, 0);
      chk("cleared", 32'h33, rd_q);
      $display("test interrupt done");
      bus(0, `REG_CLASSIFIED, 0);
      chk("classified", 32'h21, rd_q);
      bus(0, `REG_REPORTED, 0);
      chk("reported", 32'h15, rd_q);
      bus(0, `REG_HITS_LO, 0);
      chk("hits lo", 32'h0C000C14, rd_q);
      bus(0, `REG_HITS_HI, 0);
      chk("hits hi", 32'h0000110C, rd_q);
      bus(0, `REG_LAST, 0);
      chk("last", 32'h0002203B, rd_q);
      wsel = 4'hE;
      bus(1, `REG_IRQ_MASK, 32'h3F);
      wsel = 4'hF;
      bus(0, `REG_IRQ_MASK, 0);
      chk("sel ignored", 32'h08, rd_q);
      bus(1, `REG_CTRL, 32'h3);
      bus(0, `REG_CLASSIFIED, 0);
      chk("count clear", 32'h0, rd_q);
      bus(0, `REG_CTRL, 0);
      chk("ctrl kept", 32'h1, rd_q);
      $display("test counters done");
      bus(1, `REG_CTRL, 32'h0);
      i_model.issue(4'h3, 8'h00, 6'h3F);
      #1;
      chk("off valid", 32'h1, {31'h0, res_vld});
      chk("off elig", {26'h0, 6'h3B}, {26'h0, elig});
      chk("off flags", 32'h0, {26'h0, flags});
      bus(0, `REG_CLASSIFIED, 0);
      chk("off count", 32'h1, rd_q);
      bus(0, `REG_REPORTED, 0);
      chk("off report", 32'h0, rd_q);
      bus(0, `REG_STATUS, 0);
      chk("off status", 32'h33, rd_q);
      $display("test disable done");
      summarize;
   end
   initial begin
      #(25 * 3000);
      bad_count = bad_count + 1;
      summarize;
   end
endmodule
bind simd_fp_exception_classifier simd_fp_exc_props i_props (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .in_valid_i(in_valid_i), .class_i(class_i),
   .imm_i(imm_i), .detect_i(detect_i), .res_valid_o(res_valid_o), .elig_o(elig_o),
   .flags_o(flags_o), .irq_o(irq_o));
